// file: core/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // axi-lite register byte offsets
  localparam logic [7:0] ExtCtrlOffset    = 8'h00;  // ext_request_status_control
  localparam logic [7:0] SrcFlagOffset    = 8'h04;  // source flags (read)
  localparam logic [7:0] SrcEnableOffset  = 8'h08;  // local enables
  localparam logic [7:0] CpuCtrlOffset    = 8'h0c;  // global mask, entry/return strobes
  localparam logic [7:0] VectorOffset     = 8'h10;  // winning vector (read)
  localparam logic [7:0] FrameOffset      = 8'h14;  // pc in, frame status
  localparam logic [7:0] StackPtrOffset   = 8'h18;  // stack_pointer
  localparam logic [7:0] FrameBase        = 8'h20;  // five frame bytes, 4 bytes apart

  // ext_request_status_control fields
  localparam int ExtPinEnableBit  = 0;
  localparam int LevelSelectBit   = 1;
  localparam int ExtIntEnableBit  = 2;
  localparam int PullupDisableBit = 3;
  localparam int ExtAckBit        = 4;
  localparam int ExtFlagBit       = 5;
  localparam int PinLevelBit      = 6;

  // cpu control fields
  localparam int GlobalMaskBit  = 0;
  localparam int EntryBit       = 1;
  localparam int ReturnBit      = 2;

  // sources, index 0 = highest priority among those handled here
  localparam int NumSrc = 10;
  localparam int SrcExt = 0;
  localparam int SrcRxFull = 1;
  localparam int SrcIdle = 2;
  localparam int SrcTxEmpty = 3;
  localparam int SrcTxDone = 4;
  localparam int SrcTwoWire = 5;
  localparam int SrcKeypad = 6;
  localparam int SrcConv = 7;
  localparam int SrcComp = 8;
  localparam int SrcWake = 9;

  // vector addresses, high byte at the lower address
  localparam logic [15:0] VecReset    = 16'hfffe;
  localparam logic [15:0] VecExt      = 16'hfffa;
  localparam logic [15:0] VecRx       = 16'hffe0;
  localparam logic [15:0] VecTx       = 16'hffde;
  localparam logic [15:0] VecTwoWire  = 16'hffdc;
  localparam logic [15:0] VecKeypad   = 16'hffda;
  localparam logic [15:0] VecConv     = 16'hffd8;
  localparam logic [15:0] VecComp     = 16'hffd6;
  localparam logic [15:0] VecWake     = 16'hffd0;
  localparam logic [15:0] VecUserLow  = 16'hffc0;  // user vectors, never selected
  localparam logic [15:0] VecUserHigh = 16'hffce;

  localparam logic [7:0]  StackReset  = 8'hff;
  localparam int          FrameLen    = 5;
  localparam logic [1:0]  RespOkay    = 2'b00;
  localparam logic [1:0]  RespSlvErr  = 2'b10;

  typedef enum logic [2:0] {
    Idle   = 3'b001,
    Push   = 3'b010,
    Pop    = 3'b100
  } seq_t;
endpackage : irq_ctrl_pkg

// file: core/irq_ctrl.sv
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - push pcl, pch, x, a, ccr in order
// - stack pointer ends one below ccr
// - saved pc is next main-program instruction
// - index high byte never stacked
// - return pops reverse, then fetch three bytes
// - request needs flag and local enable, mask clear
// - entry stacks frame, sets mask, picks vector
// - vector high byte at lower address
// - lower vector number means higher priority
// - vectors 31 to 24 have no source
// - shared tx and rx vectors, own enables
// - pin ignored unless pin enable set
// - synchronous sampling, edge or edge-and-level
// - asynchronous wake path in stop mode
// - select bit chooses edge or edge-level
// - pin event interrupts or only polls
// - pullup on only when pin enable set and pullup disable clear
// - flag sets on deasserted-to-asserted edge
// - level mode holds flag while asserted
// - pin level visible for branch instructions
// - global mask set by every reset
// - reset vector at fffe:ffff
// - highest priority pending served first
module irq_ctrl (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // external request pin, active low, and stop mode
  input  wire logic                 extPinN,
  input  wire logic                 stopMode,
  output logic                      pullupEnable,
  output logic                      stopWake,
  // peripheral flags, level, cleared in the peripherals
  input  wire logic [irq_ctrl_pkg::NumSrc-1:0] periphFlag,
  // cpu side
  output logic                      cpuRequest,
  output logic [15:0]               vectorAddr
);
  import irq_ctrl_pkg::*;

  // configuration registers
  logic             pinEnable_q, levelSel_q, extIntEn_q, pullupDis_q;
  logic             extFlag_q, extFlag_d;
  logic [NumSrc-1:0] srcEnable_q;        // local enables
  logic             globalMask_q;        // ccr i bit
  logic [7:0]       stackPtr_q;          // stack_pointer
  logic [15:0]      pcIn_q;              // next main-program pc
  logic [7:0]       xLow_q, acc_q, ccr_q;
  logic [7:0]       frame_q [FrameLen];  // stack image, index = push order
  logic [2:0]       seqCnt_q;
  seq_t             seq_q;
  logic [1:0]       fetchCnt_q;          // return refill count
  logic [15:0]      vector_q;
  logic             request_q;

  // pin synchroniser, first stage read only by the second
  logic pinSync1_q, pinSync2_q, pinPrev_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      pinSync1_q <= 1'b1;
      pinSync2_q <= 1'b1;
      pinPrev_q  <= 1'b1;
    end else begin
      pinSync1_q <= extPinN;
      pinSync2_q <= pinSync1_q;
      pinPrev_q  <= pinSync2_q;
    end
  end

  // asserted means low; edge is high-to-low
  wire pinAsserted = ~pinSync2_q;
  wire pinEdge     = pinPrev_q & ~pinSync2_q;

  // axi write decode: take address and data together, one write at a time
  wire        wrFire   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire        wrExt    = wrFire & (s_axi_awaddr == ExtCtrlOffset) & s_axi_wstrb[0];
  wire        wrEnable = wrFire & (s_axi_awaddr == SrcEnableOffset) & s_axi_wstrb[1:0] != 2'b00;
  wire        wrCpu    = wrFire & (s_axi_awaddr == CpuCtrlOffset) & s_axi_wstrb[0];
  wire        wrPc     = wrFire & (s_axi_awaddr == FrameOffset) & (&s_axi_wstrb[1:0]);
  wire        wrRegs   = wrFire & (s_axi_awaddr == StackPtrOffset);
  wire        wrKnown  = (s_axi_awaddr == ExtCtrlOffset) | (s_axi_awaddr == SrcEnableOffset)
                       | (s_axi_awaddr == CpuCtrlOffset) | (s_axi_awaddr == FrameOffset)
                       | (s_axi_awaddr == StackPtrOffset);
  wire        ackWrite = wrExt & s_axi_wdata[ExtAckBit];
  wire        entryReq = wrCpu & s_axi_wdata[EntryBit] & (seq_q == Idle);
  wire        returnReq = wrCpu & s_axi_wdata[ReturnBit] & (seq_q == Idle);

  wire pinSet = pinEnable_q & (pinEdge | (levelSel_q & pinAsserted));
  wire levelHold = pinEnable_q & levelSel_q & pinAsserted;

  // external flag: set wins over clear
  always_comb begin
    extFlag_d = extFlag_q;
    if (ackWrite & ~levelHold)
      extFlag_d = 1'b0;
    if (pinSet)
      extFlag_d = 1'b1;
  end

  wire extPending = extFlag_q & extIntEn_q;
  // tx/rx sources gated each by their own enable
  // stays while flag and enable hold
  wire [NumSrc-1:0] pending = {periphFlag[NumSrc-1:1] & srcEnable_q[NumSrc-1:1], extPending};

  logic [15:0] winVector;
  always_comb begin
    winVector = VecReset;
    for (int i = NumSrc - 1; i >= 0; i--) begin
      if (pending[i]) begin
        case (i)
          SrcExt:                  winVector = VecExt;
          SrcRxFull, SrcIdle:      winVector = VecRx;
          SrcTxEmpty, SrcTxDone:   winVector = VecTx;
          SrcTwoWire:              winVector = VecTwoWire;
          SrcKeypad:               winVector = VecKeypad;
          SrcConv:                 winVector = VecConv;
          SrcComp:                 winVector = VecComp;
          default:                 winVector = VecWake;
        endcase
      end
    end
  end

  // control register process
  always_ff @(posedge clock) begin
    if (reset) begin
      pinEnable_q  <= 1'b0;
      levelSel_q   <= 1'b0;
      extIntEn_q   <= 1'b0;
      pullupDis_q  <= 1'b0;
      srcEnable_q  <= '0;
      pcIn_q       <= '0;
      xLow_q       <= '0;
      acc_q        <= '0;
      ccr_q        <= '0;
    end else begin
      if (wrExt) begin
        pinEnable_q <= s_axi_wdata[ExtPinEnableBit];
        levelSel_q  <= s_axi_wdata[LevelSelectBit];
        extIntEn_q  <= s_axi_wdata[ExtIntEnableBit];
        pullupDis_q <= s_axi_wdata[PullupDisableBit];
      end
      if (wrEnable)
        srcEnable_q <= s_axi_wdata[NumSrc-1:0];
      if (wrPc)
        pcIn_q <= s_axi_wdata[15:0];
      if (wrRegs) begin
        xLow_q <= s_axi_wdata[15:8];
        acc_q  <= s_axi_wdata[23:16];
        ccr_q  <= s_axi_wdata[31:24];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset)
      extFlag_q <= 1'b0;
    else
      extFlag_q <= extFlag_d;
  end

  // entry / return sequencer, one frame byte per clock
  always_ff @(posedge clock) begin
    if (reset) begin
      seq_q        <= Idle;
      seqCnt_q     <= '0;
      fetchCnt_q   <= '0;
      stackPtr_q   <= StackReset;
      globalMask_q <= 1'b1;
      vector_q     <= VecReset;
      for (int i = 0; i < FrameLen; i++)
        frame_q[i] <= '0;
    end else begin
      case (seq_q)
        Idle: begin
          if (wrCpu)
            globalMask_q <= s_axi_wdata[GlobalMaskBit];
          if (wrRegs && !s_axi_wdata[0])
            stackPtr_q <= s_axi_wdata[7:0];
          if (fetchCnt_q != 2'd0)
            fetchCnt_q <= fetchCnt_q - 2'd1;
          if (entryReq && !globalMask_q && pending != '0) begin
            seq_q    <= Push;
            seqCnt_q <= '0;
          end else if (returnReq) begin
            seq_q    <= Pop;
            seqCnt_q <= 3'(FrameLen - 1);
          end
        end
        Push: begin
          case (seqCnt_q)
            3'd0:    frame_q[0] <= pcIn_q[7:0];
            3'd1:    frame_q[1] <= pcIn_q[15:8];
            3'd2:    frame_q[2] <= xLow_q;
            3'd3:    frame_q[3] <= acc_q;
            default: frame_q[4] <= ccr_q;
          endcase
          stackPtr_q <= stackPtr_q - 8'd1;
          seqCnt_q   <= seqCnt_q + 3'd1;
          if (seqCnt_q == 3'(FrameLen - 1)) begin
            globalMask_q <= 1'b1;
            vector_q     <= winVector;
            seq_q        <= Idle;
          end
        end
        Pop: begin
          stackPtr_q <= stackPtr_q + 8'd1;
          if (seqCnt_q == 3'(FrameLen - 1))
            globalMask_q <= frame_q[4][3];
          seqCnt_q <= seqCnt_q - 3'd1;
          if (seqCnt_q == 3'd0) begin
            fetchCnt_q <= 2'd3;
            seq_q      <= Idle;
          end
        end
        default: seq_q <= Idle;
      endcase
    end
  end

  // request toward cpu, registered
  always_ff @(posedge clock) begin
    if (reset)
      request_q <= 1'b0;
    else
      request_q <= (pending != '0) & ~globalMask_q;
  end

  // stop mode wake, asynchronous combinational path then captured
  wire stopWakeRaw = stopMode & pinEnable_q & ~extPinN;
  always_ff @(posedge clock) begin
    if (reset)
      stopWake <= 1'b0;
    else
      stopWake <= stopWakeRaw;
  end

  always_ff @(posedge clock) begin
    if (reset)
      pullupEnable <= 1'b0;
    else
      pullupEnable <= pinEnable_q & ~pullupDis_q;
  end

  // axi write response
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RespOkay;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= wrFire;
      s_axi_wready  <= wrFire;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrKnown ? RespOkay : RespSlvErr;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read mux
  wire        rdFire  = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
  wire [5:0]  rdSlot  = 6'((s_axi_araddr - FrameBase) >> 2);
  logic [31:0] rdData;
  logic        rdOk;
  always_comb begin
    rdOk   = 1'b1;
    rdData = '0;
    case (s_axi_araddr)
      ExtCtrlOffset: begin
        rdData[ExtPinEnableBit]  = pinEnable_q;
        rdData[LevelSelectBit]   = levelSel_q;
        rdData[ExtIntEnableBit]  = extIntEn_q;
        rdData[PullupDisableBit] = pullupDis_q;
        rdData[ExtFlagBit]       = extFlag_q;
        rdData[PinLevelBit]      = pinEnable_q & pinSync2_q;
      end
      SrcFlagOffset:   rdData[NumSrc-1:0] = {periphFlag[NumSrc-1:1], extFlag_q};
      SrcEnableOffset: rdData[NumSrc-1:0] = srcEnable_q;
      CpuCtrlOffset:   rdData[2:0] = {seq_q == Pop, seq_q == Push, globalMask_q};
      VectorOffset:    rdData[15:0] = vector_q;
      FrameOffset:     rdData = {14'h0000, fetchCnt_q, pcIn_q};
      StackPtrOffset:  rdData = {ccr_q, acc_q, xLow_q, stackPtr_q};
      default: begin
        if (s_axi_araddr >= FrameBase && rdSlot < 6'(FrameLen) && s_axi_araddr[1:0] == 2'b00)
          rdData[7:0] = frame_q[rdSlot[2:0]];
        else
          rdOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RespOkay;
    end else begin
      s_axi_arready <= rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        s_axi_rresp  <= rdOk ? RespOkay : RespSlvErr;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // registered cpu outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      cpuRequest <= 1'b0;
      vectorAddr <= VecReset;
    end else begin
      cpuRequest <= request_q;
      vectorAddr <= vector_q;
    end
  end
endmodule : irq_ctrl

// file: testbench/irq_ctrl_monitor.sv
`timescale 1ns/1ps
// port-level checker for bus answer and request latencies
module irq_ctrl_monitor (
  // clock and reset
  input wire logic                             clock,
  input wire logic                             reset,
  // register bus
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_bvalid,
  input wire logic [7:0]                       s_axi_araddr,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic [1:0]                       s_axi_rresp,
  input wire logic                             s_axi_rvalid,
  // pin, flags and cpu side
  input wire logic                             extPinN,
  input wire logic                             stopMode,
  input wire logic                             stopWake,
  input wire logic [irq_ctrl_pkg::NumSrc-1:0] periphFlag,
  input wire logic                             cpuRequest,
  input wire logic [15:0]                      vectorAddr
);
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [4:0]        quietCnt_q;  // cycles since a write or a flag change
  logic [NumSrc-1:0] flagSeen_q;  // flags one cycle ago
  // a request may only drop soon after something that can cancel it
  always_ff @(posedge clock) begin
    flagSeen_q <= periphFlag;
    if (reset || s_axi_bvalid || periphFlag != flagSeen_q) begin
      quietCnt_q <= 5'h00;
    end else if (quietCnt_q != 5'h1f) begin
      quietCnt_q <= quietCnt_q + 5'h01;
    end
  end
  chk_reset_vector: assert property ($fell(reset) |-> vectorAddr == VecReset)
    else $error("vector not at the reset entry");
  chk_mask_after_reset: assert property ($fell(reset) |-> !cpuRequest [*2])
    else $error("request raised while masked");
  chk_vector_range: assert property (vectorAddr[0] == 1'b0 && vectorAddr > VecUserHigh)
    else $error("vector outside the sourced table");
  chk_stop_wake: assert property (stopWake |-> $past(stopMode) &&
      !($past(extPinN) && $past(extPinN, 2) && $past(extPinN, 3)))
    else $error("wake without stop and low pin");
  chk_request_drop: assert property ($fell(cpuRequest) |-> quietCnt_q < 5'h0c)
    else $error("request dropped without a cause");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
      |=> s_axi_rvalid && s_axi_arready)
    else $error("read not answered next cycle");
  chk_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
      && s_axi_araddr > 8'h30 |=> s_axi_rresp == RespSlvErr)
    else $error("unmapped read not refused");
endmodule : irq_ctrl_monitor

bind irq_ctrl irq_ctrl_monitor i_irq_ctrl_monitor (
  .clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .extPinN(extPinN), .stopMode(stopMode), .stopWake(stopWake), .periphFlag(periphFlag),
  .cpuRequest(cpuRequest), .vectorAddr(vectorAddr)
);

// file: testbench/irq_far_side.sv
`timescale 1ns/1ps
// stands in for the peripherals and the board-level request pin
module irq_far_side (
  // clock and reset
  input  wire logic                             clock,
  input  wire logic                             reset,
  // bench commands
  input  wire logic [irq_ctrl_pkg::NumSrc-1:0] flagWant,
  input  wire logic                             pinDrive,
  input  wire logic                             pinLow,
  // device side
  input  wire logic                             pullupEnable,
  output logic [irq_ctrl_pkg::NumSrc-1:0]       periphFlag,
  output logic                                  extPinN
);
  import irq_ctrl_pkg::*;
  logic floatBit_q;  // an undriven, unpulled pin wanders every cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      floatBit_q <= 1'b0;
      periphFlag <= '0;
    end else begin
      floatBit_q <= !floatBit_q;
      periphFlag <= flagWant;
    end
  end
  // released pin rests high only while the pullup is on
  assign extPinN = pinDrive ? !pinLow : (pullupEnable ? 1'b1 : floatBit_q);
endmodule : irq_far_side

// file: testbench/test_irq_ctrl.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_irq_ctrl;
  import irq_ctrl_pkg::*;
  localparam logic [31:0] PinOn = 32'h1 << ExtPinEnableBit;
  localparam logic [31:0] LvlOn = 32'h1 << LevelSelectBit;
  localparam logic [31:0] IntOn = 32'h1 << ExtIntEnableBit;
  localparam logic [31:0] PudOn = 32'h1 << PullupDisableBit;
  localparam logic [31:0] AckOn = 32'h1 << ExtAckBit;
  localparam logic [31:0] FlagB = 32'h1 << ExtFlagBit;
  localparam logic [31:0] LvlB  = 32'h1 << PinLevelBit;
  logic clock = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdData;
  logic [1:0] bresp, rresp, wrResp, rdResp;
  logic awready, wready, bvalid, arready, rvalid, stopMode = 1'b0, pullupEnable, stopWake;
  logic extPinN, cpuRequest, pinDrive = 1'b1, pinLow = 1'b0;
  logic [NumSrc-1:0] periphFlag, flagWant = '0;
  logic [15:0] vectorAddr;
  int fail_count = 0, num_checks = 0, cycles = 0;
  always #4 clock = !clock;
  irq_ctrl i_irq_ctrl (.clock(clock), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .extPinN(extPinN), .stopMode(stopMode), .pullupEnable(pullupEnable),
    .stopWake(stopWake), .periphFlag(periphFlag), .cpuRequest(cpuRequest),
    .vectorAddr(vectorAddr));
  irq_far_side i_irq_far_side (.clock(clock), .reset(reset), .flagWant(flagWant),
    .pinDrive(pinDrive), .pinLow(pinLow), .pullupEnable(pullupEnable),
    .periphFlag(periphFlag), .extPinN(extPinN));
  // bus write: both channels offered together, each released when taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wrResp = bresp;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdData = rdata;
    rdResp = rresp;
  endtask : rd_reg
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    rd_reg(a);
    `CHECK(nm, e, rdData & m)
  endtask : rchk
  // lets the pin synchroniser and request pipeline catch up
  task automatic settle;
    repeat (6) @(posedge clock);
  endtask : settle
  task automatic busy_wait;
    do rd_reg(CpuCtrlOffset); while (rdData[ReturnBit:EntryBit] !== 2'b00);
  endtask : busy_wait
  task automatic check_reset;
    `CHECK("vector", VecReset, vectorAddr)
    `CHECK("pullup", 1'b0, pullupEnable)
    rchk(CpuCtrlOffset, 32'h1, 32'h1, "mask");
    rchk(StackPtrOffset, 32'hff, {24'h0, StackReset}, "sp");
  endtask : check_reset
  task automatic stop_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    logic [NumSrc-1:0] flagTab [10], enTab [10];
    logic [15:0] expTab [10], pc;
    logic [7:0] frame [FrameLen];
    for (int k = 0; k < 9; k++) begin
      flagTab[k] = (10'h3fe << k) & 10'h3fe;
      enTab[k] = 10'h3fe;
    end
    flagTab[9] = 10'h028;
    enTab[9] = 10'h3f6;
    expTab = '{VecRx, VecRx, VecTx, VecTx, VecTwoWire, VecKeypad, VecConv, VecComp, VecWake,
               VecTwoWire};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    check_reset();
    // entry and return with one to nine sources pending at once
    for (int k = 0; k < 10; k++) begin
      pc = 16'h1200 + 16'(k);
      frame = '{pc[7:0], pc[15:8], 8'h3c, 8'ha5, 8'h60};
      wr_reg(StackPtrOffset, 32'h60a53c80);
      wr_reg(FrameOffset, {16'h0, pc});
      wr_reg(SrcEnableOffset, {22'h0, enTab[k]});
      flagWant <= flagTab[k];
      wr_reg(CpuCtrlOffset, 32'h0);
      settle();
      `CHECK("request", 1'b1, cpuRequest)
      wr_reg(CpuCtrlOffset, 32'h1 << EntryBit);
      busy_wait();
      rchk(VectorOffset, 32'hffff, {16'h0, expTab[k]}, "vector");
      `CHECK("vector port", expTab[k], vectorAddr)
      for (int j = 0; j < FrameLen; j++) begin
        rchk(FrameBase + 8'(4 * j), 32'hff, {24'h0, frame[j]}, "frame");
      end
      rchk(StackPtrOffset, 32'hff, 32'h7b, "sp");
      rchk(CpuCtrlOffset, 32'h1, 32'h1, "mask");
      `CHECK("request", 1'b0, cpuRequest)
      flagWant <= '0;
      wr_reg(CpuCtrlOffset, 32'h1 << ReturnBit);
      busy_wait();
      rchk(StackPtrOffset, 32'hff, 32'h80, "sp");
      rchk(CpuCtrlOffset, 32'h1, 32'h0, "mask");
      rchk(FrameOffset, 32'h3ffff, {16'h0, pc}, "pc and fetch");
    end
    // pin ignored while its function is off
    pinLow <= 1'b1;
    settle();
    pinLow <= 1'b0;
    settle();
    rchk(ExtCtrlOffset, FlagB, 32'h0, "flag off");
    wr_reg(ExtCtrlOffset, PinOn | PudOn);
    settle();
    `CHECK("pullup", 1'b0, pullupEnable)
    wr_reg(ExtCtrlOffset, PinOn);
    pinDrive <= 1'b0;
    settle();
    `CHECK("pullup", 1'b1, pullupEnable)
    rchk(ExtCtrlOffset, LvlB | FlagB, LvlB, "pin high");
    pinDrive <= 1'b1;
    pinLow <= 1'b1;
    settle();
    rchk(ExtCtrlOffset, LvlB | FlagB, FlagB, "pin low");
    `CHECK("request", 1'b0, cpuRequest)
    pinLow <= 1'b0;
    wr_reg(ExtCtrlOffset, PinOn | AckOn);
    rchk(ExtCtrlOffset, FlagB, 32'h0, "ack");
    // level mode: flag pinned while the pin stays low
    wr_reg(ExtCtrlOffset, PinOn | IntOn | LvlOn);
    pinLow <= 1'b1;
    settle();
    `CHECK("request", 1'b1, cpuRequest)
    wr_reg(ExtCtrlOffset, PinOn | IntOn | LvlOn | AckOn);
    rchk(ExtCtrlOffset, FlagB, FlagB, "held");
    stopMode <= 1'b1;
    settle();
    `CHECK("wake", 1'b1, stopWake)
    stopMode <= 1'b0;
    pinLow <= 1'b0;
    settle();
    wr_reg(ExtCtrlOffset, PinOn | IntOn | LvlOn | AckOn);
    settle();
    rchk(ExtCtrlOffset, FlagB, 32'h0, "released");
    `CHECK("request", 1'b0, cpuRequest)
    // unmapped places are refused
    rd_reg(8'h40);
    `CHECK("rresp", RespSlvErr, rdResp)
    wr_reg(8'h1c, 32'h0);
    `CHECK("bresp", RespSlvErr, wrResp)
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    check_reset();
    stop_test();
  end
endmodule : test_irq_ctrl
